/* common/pmc_defines.svh */
// Purpose: offsets, field positions, reset values for power management block
// Assumes: word addressed config space, byte address on the port
// Notes:   included by the package user files
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_OFF_CAP        8'hC0
`define PMC_OFF_CSR        8'hC4
`define PMC_CAP_ID         8'h01
`define PMC_CAP_NEXT       8'h00
`define PMC_CAP_VERSION    3'h2
`define PMC_BIT_COLD       31
`define PMC_BIT_D2S        26
`define PMC_BIT_D1S        25
`define PMC_BIT_FLAG       15
`define PMC_BIT_EN         8
`define PMC_DATA_SELECT_FIELD_LSB       9
`define PMC_DATA_SELECT_FIELD_MSB       12
`define PMC_DATA_SELECT_FIELD_RESET     4'h0
`define PMC_STATE_RESET    2'h0
`endif

/* common/pmc_pkg.sv */
// Purpose: types shared by the power management block
// Assumes: nothing
// Notes:   constants live in pmc_defines.svh
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_D0     = 2'b00,
      PMC_D1     = 2'b01,
      PMC_D2     = 2'b10,
      PMC_D3HOT  = 2'b11
   } pmc_state_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmc_req_type;
endpackage : pmc_pkg

/* core/pmc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes:   first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module pmc_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // data
   input  wire logic din,
   output var  logic dout
);
   logic s1;
   logic s2;
   logic s3;

   // shift chain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // change accepted once two later stages agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dout <= 1'b0;
      end else if (s2 == s3) begin
         dout <= s3;
      end
   end
endmodule : pmc_sync
`default_nettype wire

/* core/pmc_regs.sv */
// Purpose: power capability and control/status registers with wake output
// Assumes: config port, read data one cycle after read strobe
// Notes:   power-up reset is arst_n; warm reset is a synchronous pulse
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_regs
   import pmc_pkg::*;
#(
   parameter logic SUPPORT_D1 = 1'b1,
   parameter logic SUPPORT_D2 = 1'b1
) (
   // clock and resets
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        warm_reset,
   // straps and events
   input  wire logic        cold_wake_support,
   input  wire logic        wake_event,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output var  logic [31:0] rdata,
   // wake output and state
   output var  logic        wake_n,
   output var  logic        wake_oe,
   output var  pmc_state_type power_state_field
);
   pmc_req_type   req;
   logic          event_sync;
   logic          event_prev;
   logic          event_pulse;
   logic          cold_q;
   logic          warm_q;
   logic          wake_event_flag;
   logic          wake_signal_enable;
   logic [3:0]    data_select_field;
   logic          csr_wr;
   logic          flag_clear;
   logic          state_ok;
   logic [31:0]   cap_word;
   logic [31:0]   csr_word;
   logic [31:0]   next_rdata;
   logic          next_wake;
   logic          state_ok_q;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // wake event pin synchroniser
   pmc_sync u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (wake_event),
      .dout   (event_sync)
   );

   // edge detect on settled event
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         event_prev <= 1'b0;
      end else begin
         event_prev <= event_sync;
      end
   end
   assign event_pulse = event_sync & ~event_prev;

   // strap pin passes the same agreement filter as the event pin
   pmc_sync u_strap_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (cold_wake_support),
      .dout   (cold_q)
   );

   // warm reset only resets wake bits without cold support
   assign warm_q = warm_reset & ~cold_q;

   assign csr_wr     = req.wr && (req.addr == `PMC_OFF_CSR);
   assign flag_clear = csr_wr && req.wdata[`PMC_BIT_FLAG];

   // wake event flag, set wins over clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_event_flag <= 1'b0;
      end else if (event_pulse) begin
         wake_event_flag <= 1'b1;
      end else if (warm_q || flag_clear) begin
         wake_event_flag <= 1'b0;
      end
   end

   // wake signal enable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_signal_enable <= 1'b0;
      end else if (warm_q) begin
         wake_signal_enable <= 1'b0;
      end else if (csr_wr) begin
         wake_signal_enable <= req.wdata[`PMC_BIT_EN];
      end
   end

   // data select, stored but unused
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_select_field <= `PMC_DATA_SELECT_FIELD_RESET;
      end else if (warm_reset) begin
         data_select_field <= `PMC_DATA_SELECT_FIELD_RESET;
      end else if (csr_wr) begin
         data_select_field <= req.wdata[`PMC_DATA_SELECT_FIELD_MSB:`PMC_DATA_SELECT_FIELD_LSB];
      end
   end

   // supported states check
   always_comb begin
      unique case (req.wdata[1:0])
         2'b00:   state_ok = 1'b1;
         2'b01:   state_ok = SUPPORT_D1;
         2'b10:   state_ok = SUPPORT_D2;
         2'b11:   state_ok = 1'b1;
      endcase
   end

   // power state, unsupported writes dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_state_field <= pmc_state_type'(`PMC_STATE_RESET);
      end else if (warm_reset) begin
         power_state_field <= pmc_state_type'(`PMC_STATE_RESET);
      end else if (csr_wr && state_ok) begin
         power_state_field <= pmc_state_type'(req.wdata[1:0]);
      end
   end

   // capability word
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[7:0] = `PMC_CAP_ID;
      cap_word[15:8] = `PMC_CAP_NEXT;
      cap_word[18:16] = `PMC_CAP_VERSION;
      cap_word[`PMC_BIT_D1S] = SUPPORT_D1;
      cap_word[`PMC_BIT_D2S] = SUPPORT_D2;
      cap_word[`PMC_BIT_COLD] = cold_q;
   end

   // control/status word, reserved and scale zero
   always_comb begin
      csr_word = 32'h0000_0000;
      csr_word[`PMC_BIT_FLAG] = wake_event_flag;
      csr_word[`PMC_DATA_SELECT_FIELD_MSB:`PMC_DATA_SELECT_FIELD_LSB] = data_select_field;
      csr_word[`PMC_BIT_EN] = wake_signal_enable;
      csr_word[1:0] = power_state_field;
   end

   // read mux, unmapped reads zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req.rd) begin
         if (req.addr == `PMC_OFF_CAP) begin
            next_rdata = cap_word;
         end else if (req.addr == `PMC_OFF_CSR) begin
            next_rdata = csr_word;
         end
      end
   end

   // read data stands one cycle only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // open-drain wake output, next value from next flag state
   assign next_wake = (event_pulse | (wake_event_flag & ~(warm_q | flag_clear)))
                      & (warm_q ? 1'b0 : (csr_wr ? req.wdata[`PMC_BIT_EN] : wake_signal_enable));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_oe <= 1'b0;
         wake_n  <= 1'b1;
      end else begin
         wake_oe <= next_wake;
         wake_n  <= ~next_wake;
      end
   end

   // checks
   property p_wake_tracks;
      @(posedge clk) disable iff (!arst_n)
         wake_oe == (wake_event_flag & wake_signal_enable);
   endproperty
   a_wake_tracks: assert property (p_wake_tracks) else $error("wake output mismatch");

   property p_cap_id;
      @(posedge clk) disable iff (!arst_n)
         (rd && addr == `PMC_OFF_CAP) |=> rdata[7:0] == 8'h01;
   endproperty
   a_cap_id: assert property (p_cap_id) else $error("capability id wrong");

   property p_flag_set;
      @(posedge clk) disable iff (!arst_n)
         event_pulse |=> wake_event_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

   property p_flag_clear;
      @(posedge clk) disable iff (!arst_n)
         (flag_clear && !event_pulse) |=> !wake_event_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_flag_keep;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && !wdata[15] && !warm_q) |=> wake_event_flag == $past(wake_event_flag) || $past(event_pulse);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("zero write changed flag");

   property p_warm_keep;
      @(posedge clk) disable iff (!arst_n)
         (warm_reset && cold_q && !csr_wr) |=> wake_signal_enable == $past(wake_signal_enable);
   endproperty
   a_warm_keep: assert property (p_warm_keep) else $error("enable lost on warm reset");

   property p_enable_write;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && !warm_q) |=> wake_signal_enable == $past(wdata[8]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_csr_zero;
      @(posedge clk) disable iff (!arst_n)
         (rd && addr == `PMC_OFF_CSR) |=> (rdata[31:16] == 16'h0000) && (rdata[14:13] == 2'b00) && (rdata[7:2] == 6'h00);
   endproperty
   a_csr_zero: assert property (p_csr_zero) else $error("reserved bits nonzero");

   property p_state_write;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && !warm_reset) |=> power_state_field == (state_ok_q ? $past(wdata[1:0]) : $past(power_state_field));
   endproperty
   // state check delayed to line up with the write it judged
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ok_q <= 1'b0;
      end else begin
         state_ok_q <= state_ok;
      end
   end
   a_state_write: assert property (p_state_write) else $error("power state write wrong");

   property p_supports;
      @(posedge clk) disable iff (!arst_n)
         (rd && addr == `PMC_OFF_CAP) |=> rdata[26:25] == {SUPPORT_D2, SUPPORT_D1};
   endproperty
   a_supports: assert property (p_supports) else $error("low states not reported");

   property p_warm_clear;
      @(posedge clk) disable iff (!arst_n)
         (warm_reset && !cold_q && !event_pulse) |=> !wake_event_flag && !wake_signal_enable;
   endproperty
   a_warm_clear: assert property (p_warm_clear) else $error("warm reset kept wake bits");

   property p_flag_warm_keep;
      @(posedge clk) disable iff (!arst_n)
         (warm_reset && cold_q && wake_event_flag && !flag_clear) |=> wake_event_flag;
   endproperty
   a_flag_warm_keep: assert property (p_flag_warm_keep) else $error("flag lost on warm reset");

   property p_flag_hold;
      @(posedge clk) disable iff (!arst_n)
         (wake_event_flag && !flag_clear && !warm_q) |=> wake_event_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");

   property p_wake_clear;
      @(posedge clk) disable iff (!arst_n)
         (flag_clear && !event_pulse) |=> !wake_oe && wake_n;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake output kept after clear");

   property p_enable_hold;
      @(posedge clk) disable iff (!arst_n)
         (!csr_wr && !warm_q) |=> $stable(wake_signal_enable);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");

   property p_select_write;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && !warm_reset) |=> data_select_field == $past(wdata[12:9]);
   endproperty
   a_select_write: assert property (p_select_write) else $error("data select write lost");

   property p_select_hold;
      @(posedge clk) disable iff (!arst_n)
         (!csr_wr && !warm_reset) |=> $stable(data_select_field);
   endproperty
   a_select_hold: assert property (p_select_hold) else $error("data select changed alone");

   property p_state_accept;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && state_ok && !warm_reset) |=> power_state_field == $past(wdata[1:0]);
   endproperty
   a_state_accept: assert property (p_state_accept) else $error("supported state not taken");

   property p_state_refuse;
      @(posedge clk) disable iff (!arst_n)
         (csr_wr && !state_ok && !warm_reset) |=> $stable(power_state_field);
   endproperty
   a_state_refuse: assert property (p_state_refuse) else $error("unsupported state taken");

   property p_warm_state;
      @(posedge clk) disable iff (!arst_n)
         warm_reset |=> (power_state_field == PMC_D0) && (data_select_field == `PMC_DATA_SELECT_FIELD_RESET);
   endproperty
   a_warm_state: assert property (p_warm_state) else $error("warm reset kept state");

   property p_wake_pin;
      @(posedge clk) disable iff (!arst_n)
         wake_n == !wake_oe;
   endproperty
   a_wake_pin: assert property (p_wake_pin) else $error("wake pin and enable disagree");

   property p_read_idle;
      @(posedge clk) disable iff (!arst_n)
         (!rd || (addr != `PMC_OFF_CAP && addr != `PMC_OFF_CSR)) |=> rdata == 32'h0000_0000;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data not zero");

   property p_csr_read;
      @(posedge clk) disable iff (!arst_n)
         (rd && addr == `PMC_OFF_CSR) |=> (rdata[15] == $past(wake_event_flag))
            && (rdata[8] == $past(wake_signal_enable)) && (rdata[1:0] == $past(power_state_field));
   endproperty
   a_csr_read: assert property (p_csr_read) else $error("control word read wrong");

   property p_cold_report;
      @(posedge clk) disable iff (!arst_n)
         (rd && addr == `PMC_OFF_CAP) |=> rdata[31] == $past(cold_q);
   endproperty
   a_cold_report: assert property (p_cold_report) else $error("cold wake bit wrong");

   // main scenarios seen
   c_wake: cover property (@(posedge clk) disable iff (!arst_n) $rose(wake_oe));
   c_refuse: cover property (@(posedge clk) disable iff (!arst_n) csr_wr && !state_ok);
   c_warm_cold: cover property (@(posedge clk) disable iff (!arst_n) warm_reset && cold_q && wake_event_flag);
   c_clear: cover property (@(posedge clk) disable iff (!arst_n) flag_clear && wake_event_flag);
   c_d3: cover property (@(posedge clk) disable iff (!arst_n) power_state_field == PMC_D3HOT);
endmodule : pmc_regs
`default_nettype wire

/* test/tb.sv */
// Purpose: self-checking bench for the power management register block
// Assumes: all power states supported in i_pmc_regs; i_pmc_regs_b supports only D0 and D3hot
// Notes:   random control words from a fixed seed; model kept in bench variables
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
`define TB_CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   import pmc_pkg::*;
   logic          clk;
   logic          arst_n;
   logic          warm_reset;
   logic          cold_wake_support;
   logic          wake_event;
   logic [7:0]    addr;
   logic [31:0]   wdata;
   logic          wr;
   logic          rd;
   logic [31:0]   rdata;
   logic [31:0]   rdata_b;
   logic          wake_n;
   logic          wake_oe;
   pmc_state_type power_state_field;
   pmc_state_type state_b;
   int            fail_count;
   int            compares;
   int            cycles;
   logic [31:0]   rv;
   logic          exp_flag;
   logic          exp_en;
   logic [3:0]    exp_sel;
   logic [1:0]    exp_state;
   logic [1:0]    exp_state_b;

   // full register set and a reduced one for state refusal
   pmc_regs i_pmc_regs (.clk(clk), .arst_n(arst_n), .warm_reset(warm_reset),
      .cold_wake_support(cold_wake_support), .wake_event(wake_event), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .wake_n(wake_n), .wake_oe(wake_oe),
      .power_state_field(power_state_field));
   pmc_regs #(.SUPPORT_D1(1'b0), .SUPPORT_D2(1'b0)) i_pmc_regs_b (.clk(clk), .arst_n(arst_n),
      .warm_reset(warm_reset), .cold_wake_support(cold_wake_support), .wake_event(wake_event),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_b), .wake_n(), .wake_oe(),
      .power_state_field(state_b));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // expected control/status word from the model
   function automatic logic [31:0] exp_csr();
      return {16'h0000, exp_flag, 2'b00, exp_sel, exp_en, 6'h00, exp_state};
   endfunction : exp_csr

   // verdict and end of run
   task automatic finish_test();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   // one write cycle
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : bus_wr

   // one read cycle, data taken in the following cycle
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   // write control/status and update the model
   task automatic wr_csr(input logic [31:0] d);
      bus_wr(`PMC_OFF_CSR, d);
      exp_sel = d[12:9];
      exp_en  = d[8];
      if (d[15])
         exp_flag = 1'b0;
      exp_state = d[1:0];
      if (d[1:0] == 2'b00 || d[1:0] == 2'b11)
         exp_state_b = d[1:0];
   endtask : wr_csr

   // read back control/status and compare it, both power states and the wake outputs
   task automatic check_all();
      bus_rd(`PMC_OFF_CSR, rv);
      `TB_CHK(rv, exp_csr())
      `TB_CHK(2'(power_state_field), exp_state)
      `TB_CHK(2'(state_b), exp_state_b)
      `TB_CHK(rdata_b[1:0], exp_state_b)
      `TB_CHK(wake_oe, exp_flag & exp_en)
      `TB_CHK(wake_n, ~(exp_flag & exp_en))
   endtask : check_all

   // wake event pin pulse, long enough for the synchroniser
   task automatic wake_pulse();
      @(posedge clk);
      wake_event <= 1'b1;
      repeat (6) @(posedge clk);
      wake_event <= 1'b0;
      repeat (6) @(posedge clk);
      exp_flag = 1'b1;
   endtask : wake_pulse

   // one cycle warm reset
   task automatic warm_pulse();
      @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
      exp_state   = 2'b00;
      exp_state_b = 2'b00;
      exp_sel     = 4'h0;
      if (!cold_wake_support) begin
         exp_flag = 1'b0;
         exp_en   = 1'b0;
      end
   endtask : warm_pulse

   // main sequence
   initial begin
      arst_n = 1'b0; warm_reset = 1'b0; cold_wake_support = 1'b0; wake_event = 1'b0;
      addr = 8'h00; wdata = 32'h00000000; wr = 1'b0; rd = 1'b0;
      fail_count = 0; compares = 0; cycles = 0;
      exp_flag = 1'b0; exp_en = 1'b0; exp_sel = 4'h0; exp_state = 2'b00; exp_state_b = 2'b00;
      void'($urandom(54));
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      // reset values and capability word
      bus_rd(`PMC_OFF_CAP, rv);
      `TB_CHK(rv[7:0], 8'h01)
      `TB_CHK(rv[26:25], 2'b11)
      `TB_CHK(rdata_b[26:25], 2'b00)
      `TB_CHK(rv[31], 1'b0)
      check_all();
      $display("test reset done");
      // corner words then random control words
      for (int i = 0; i < 24; i++) begin
         rv = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : $urandom;
         wr_csr(rv);
         check_all();
      end
      // every power state code in turn
      for (int s = 3; s >= 0; s--) begin
         wr_csr({30'h00000000, 2'(s)});
         check_all();
      end
      // unmapped place reads zero, writes there ignored
      bus_rd(8'hC8, rv);
      `TB_CHK(rv, 32'h00000000)
      bus_wr(8'hC8, 32'hFFFFFFFF);
      check_all();
      $display("test writes done");
      // event with enable off, then enable, zero write, one write
      wr_csr(32'h00000000);
      wake_pulse();
      check_all();
      wr_csr(32'h00000100);
      check_all();
      wr_csr(32'h00000100);
      check_all();
      wr_csr(32'h00008100);
      check_all();
      $display("test wake done");
      // warm reset without cold wake support clears flag and enable
      wake_pulse();
      wr_csr(32'h00000B03);
      warm_pulse();
      check_all();
      // with cold wake support they survive warm reset
      @(posedge clk);
      cold_wake_support <= 1'b1;
      repeat (6) @(posedge clk);
      bus_rd(`PMC_OFF_CAP, rv);
      `TB_CHK(rv[31], 1'b1)
      wake_pulse();
      wr_csr(32'h00000B03);
      warm_pulse();
      check_all();
      // power-up reset clears them anyway
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      exp_flag = 1'b0; exp_en = 1'b0; exp_sel = 4'h0; exp_state = 2'b00; exp_state_b = 2'b00;
      check_all();
      $display("test resets done");
      finish_test();
   end
endmodule : tb
`default_nettype wire
